// ---- shared/sraf_pkg.sv ----
package sraf_pkg;

  // ----------------------------------------------------------------
  // Register map: printed offsets are indices, byte address is 4x
  // ----------------------------------------------------------------
  localparam logic [7:0] PORT_CONTROL_IDX        = 8'h10;
  localparam logic [7:0] PORT_STATUS_CONTROL_IDX = 8'h11;
  localparam logic [7:0] PORT_DATA_IDX           = 8'h12;
  localparam logic [7:0] PORT_CONTROL_ADDR        = 8'(PORT_CONTROL_IDX * 4);
  localparam logic [7:0] PORT_STATUS_CONTROL_ADDR = 8'(PORT_STATUS_CONTROL_IDX * 4);
  localparam logic [7:0] PORT_DATA_ADDR           = 8'(PORT_DATA_IDX * 4);

  // port_control field positions
  localparam int CTL_RX_FULL_IRQ_EN = 7;
  localparam int CTL_CONTROLLER_SEL = 5;
  localparam int CTL_CLOCK_POLARITY = 4;
  localparam int CTL_CLOCK_PHASE    = 3;
  localparam int CTL_WIRED_OR_MODE  = 2;
  localparam int CTL_BLOCK_ENABLE   = 1;
  localparam int CTL_TX_EMPTY_IRQ_EN = 0;
  localparam logic [7:0] CTL_RESET  = 8'h28;
  localparam logic [7:0] CTL_WMASK  = 8'hbf;

  // port_status_control field positions
  localparam int STS_RX_FULL        = 7;
  localparam int STS_ERROR_IRQ_EN   = 6;
  localparam int STS_OVERRUN        = 5;
  localparam int STS_MODE_FAULT     = 4;
  localparam int STS_TX_EMPTY       = 3;
  localparam int STS_MODE_FAULT_EN  = 2;
  localparam int STS_RATE_HI        = 1;
  localparam int STS_RATE_LO        = 0;
  localparam logic [7:0] STS_RESET  = 8'h08;

  // Rate divisors for codes 00, 01, 10, 11
  localparam logic [7:0] RATE_DIV_00 = 8'h02;
  localparam logic [7:0] RATE_DIV_01 = 8'h08;
  localparam logic [7:0] RATE_DIV_10 = 8'h20;
  localparam logic [7:0] RATE_DIV_11 = 8'h80;

  // Serial clock edges per byte: eight cycles, two edges each
  localparam logic [3:0] LAST_EDGE   = 4'hf;
  // Idle load must finish within this many bus cycles
  localparam int IDLE_LOAD_CYCLES    = 2;

  // Synchroniser lanes
  localparam int LANE_SCK  = 0;
  localparam int LANE_MOSI = 1;
  localparam int LANE_MISO = 2;
  localparam int LANE_SS   = 3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_DONE = 2'b10
  } sraf_state_t;

  // Serial pin triple: clock, controller-out, target-out
  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
  } sraf_pins_t;

endpackage : sraf_pkg

// ---- design/sraf_core.sv ----
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
// What this block does
// - Receive-full interrupt enable gates receive-full onto the interrupt; reset clears it.
// - Controller-select 1 means controller role, 0 target; reset sets it.
// - Clock polarity sets idle clock level, reset clears; both ends must match.
// - Phase 0 target starts at select fall, drives MSB on MISO; phase resets 1.
// - Phase 0 target takes no new byte mid transfer; software loads beforehand.
// - Phase 1 target starts transfer at first serial clock edge.
// - Select high: MISO released, clocks ignored, transfer state kept.
// - Wired-OR mode makes clock, MOSI, MISO open drain; else push-pull.
// - Block enable turns port on; clearing it partially resets; reset clears.
// - Transmit-empty interrupt enable gates transmit-empty; reset clears it.
// - Receive-full sets on each received byte; data read or reset clears.
// - Error interrupt enable gates overrun and mode-fault; reset clears it.
// - Byte arriving while receive full sets overrun, keeps old byte, drops new.
// - Overrun clears by status read seeing it, then data read; or reset.
// - Mode fault: target select rises mid transfer; controller select low.
// - Mode fault clears by status read seeing it, then data write; or reset.
// - Transmit-empty sets when byte moves to shift register; reset sets it.
// - Idle port loads written byte within two cycles; active target waits.
// - Fault detect enable permits fault; clearing keeps flag; controller ignores select.
// - Controller rate code selects divisor 2, 8, 32, 128; target ignores; reset clears.
// - Data writes fill transmit buffer, reads return separate receive buffer.
// - Each transfer swaps one byte over eight serial clock cycles.
module sraf_core (
  input  wire logic              clk,          // Bus clock, 100 MHz
  input  wire logic              reset,        // Synchronous, active high
  input  wire logic              awvalid,      // AXI write address valid
  output logic                   awready,      // AXI write address ready
  input  wire logic [7:0]        awaddr,       // AXI write byte address
  input  wire logic              wvalid,       // AXI write data valid
  output logic                   wready,       // AXI write data ready
  input  wire logic [31:0]       wdata,        // AXI write data
  input  wire logic [3:0]        wstrb,        // AXI byte enables
  output logic                   bvalid,       // AXI write response valid
  input  wire logic              bready,       // AXI write response ready
  output logic [1:0]             bresp,        // AXI write response
  input  wire logic              arvalid,      // AXI read address valid
  output logic                   arready,      // AXI read address ready
  input  wire logic [7:0]        araddr,       // AXI read byte address
  output logic                   rvalid,       // AXI read data valid
  input  wire logic              rready,       // AXI read data ready
  output logic [31:0]            rdata,        // AXI read data
  output logic [1:0]             rresp,        // AXI read response
  input  wire sraf_pkg::sraf_pins_t pinIn,     // Serial pin levels
  output sraf_pkg::sraf_pins_t   pinOut,       // Serial pin drive values
  output sraf_pkg::sraf_pins_t   pinOe,        // Serial pin enables
  input  wire logic              selectN,      // Select pin, active low
  output logic                   irqReq        // Interrupt request, level
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Half serial clock period in bus cycles
  function automatic logic [7:0] rateDivisor(input logic [1:0] code);
    case (code)
      2'b00:   rateDivisor = sraf_pkg::RATE_DIV_00;
      2'b01:   rateDivisor = sraf_pkg::RATE_DIV_01;
      2'b10:   rateDivisor = sraf_pkg::RATE_DIV_10;
      default: rateDivisor = sraf_pkg::RATE_DIV_11;
    endcase
  endfunction : rateDivisor

  // Open drain never drives high; push-pull drives both levels while active
  function automatic logic [1:0] padDrive(input logic val, input logic wom, input logic act);
    padDrive = wom ? {1'b0, act & ~val} : {val, act};
  endfunction : padDrive

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0]            ctl_q;
  logic                  error_irq_en_q;
  logic                  mode_fault_detect_en_q;
  logic [1:0]            rate_q;
  logic                  rxFull_q;
  logic                  ovr_q;
  logic                  mode_fault_flag_q;
  logic                  ovrArm_q;
  logic                  modfArm_q;
  logic [7:0]            rxData_q;
  logic [7:0]            txBuf_q;
  logic                  txFull_q;
  sraf_pkg::sraf_state_t state_q;
  logic [7:0]            shift_q;
  logic                  rxBit_q;
  logic [3:0]            edgeCnt_q;
  logic [7:0]            halfCnt_q;
  logic                  sckLvl_q;
  logic [3:0]            s1_q;
  logic [3:0]            s2_q;
  logic [3:0]            s3_q;
  logic [3:0]            f_q;
  logic                  awHeld_q;
  logic [7:0]            awAddr_q;
  logic                  wHeld_q;
  logic [7:0]            wByte_q;
  logic                  wLane_q;

  logic rxIe, ctrlRole, clock_polarity, clock_phase, wom, enable, txIe;
  assign rxIe     = ctl_q[sraf_pkg::CTL_RX_FULL_IRQ_EN];
  assign ctrlRole = ctl_q[sraf_pkg::CTL_CONTROLLER_SEL];
  assign clock_polarity     = ctl_q[sraf_pkg::CTL_CLOCK_POLARITY];
  assign clock_phase     = ctl_q[sraf_pkg::CTL_CLOCK_PHASE];
  assign wom      = ctl_q[sraf_pkg::CTL_WIRED_OR_MODE];
  assign enable   = ctl_q[sraf_pkg::CTL_BLOCK_ENABLE];
  assign txIe     = ctl_q[sraf_pkg::CTL_TX_EMPTY_IRQ_EN];

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] rawIn;
  logic [3:0] chg;
  assign rawIn = {selectN, pinIn.miso, pinIn.mosi, pinIn.sck};
  // A level counts only once stages two and three agree
  assign chg   = ~(s2_q ^ s3_q) & (s3_q ^ f_q);

  always_ff @(posedge clk) begin
    if (reset) begin
      s1_q <= 4'hf;
      s2_q <= 4'hf;
      s3_q <= 4'hf;
      f_q  <= 4'hf;
    end else begin
      s1_q <= rawIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q  <= f_q ^ chg;
    end
  end

  logic ssLow, ssRise, ssFall, sckChg, serIn;
  assign ssLow  = ~f_q[sraf_pkg::LANE_SS];
  assign ssRise = chg[sraf_pkg::LANE_SS] & s3_q[sraf_pkg::LANE_SS];
  assign ssFall = chg[sraf_pkg::LANE_SS] & ~s3_q[sraf_pkg::LANE_SS];
  assign sckChg = chg[sraf_pkg::LANE_SCK];
  assign serIn  = ctrlRole ? f_q[sraf_pkg::LANE_MISO] : f_q[sraf_pkg::LANE_MOSI];

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic       doWrite, arTake, dataRd, statusRd, dataWr;
  assign awready  = ~awHeld_q & ~bvalid;
  assign wready   = ~wHeld_q & ~bvalid;
  assign arready  = ~rvalid;
  assign doWrite  = awHeld_q & wHeld_q;
  assign arTake   = arvalid & arready;
  assign dataRd   = arTake & (araddr == sraf_pkg::PORT_DATA_ADDR);
  assign statusRd = arTake & (araddr == sraf_pkg::PORT_STATUS_CONTROL_ADDR);
  assign dataWr   = doWrite & wLane_q & (awAddr_q == sraf_pkg::PORT_DATA_ADDR);

  // Address and data are caught in either order, then applied together
  always_ff @(posedge clk) begin
    if (reset) begin
      awHeld_q <= 1'b0;
      awAddr_q <= 8'h00;
      wHeld_q  <= 1'b0;
      wByte_q  <= 8'h00;
      wLane_q  <= 1'b0;
      bvalid   <= 1'b0;
      bresp    <= sraf_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= awaddr;
      end
      if (wvalid && wready) begin
        wHeld_q <= 1'b1;
        wByte_q <= wdata[7:0];
        wLane_q <= wstrb[0];
      end
      if (doWrite) begin
        awHeld_q <= 1'b0;
        wHeld_q  <= 1'b0;
        bvalid   <= 1'b1;
        bresp    <= (awAddr_q == sraf_pkg::PORT_CONTROL_ADDR ||
                     awAddr_q == sraf_pkg::PORT_STATUS_CONTROL_ADDR ||
                     awAddr_q == sraf_pkg::PORT_DATA_ADDR) ?
                    sraf_pkg::RESP_OKAY : sraf_pkg::RESP_DECERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  logic [7:0] statusByte;
  assign statusByte = {rxFull_q, error_irq_en_q, ovr_q, mode_fault_flag_q, ~txFull_q, mode_fault_detect_en_q, rate_q};

  // Read answer one cycle after the address is taken
  always_ff @(posedge clk) begin
    if (reset) begin
      rvalid <= 1'b0;
      rdata  <= 32'h00000000;
      rresp  <= sraf_pkg::RESP_OKAY;
    end else if (arTake) begin
      rvalid <= 1'b1;
      rresp  <= sraf_pkg::RESP_OKAY;
      case (araddr)
        sraf_pkg::PORT_CONTROL_ADDR:        rdata <= {24'h000000, ctl_q};
        sraf_pkg::PORT_STATUS_CONTROL_ADDR: rdata <= {24'h000000, statusByte};
        sraf_pkg::PORT_DATA_ADDR:           rdata <= {24'h000000, rxData_q};
        default: begin
          rdata <= 32'h00000000;
          rresp <= sraf_pkg::RESP_DECERR;
        end
      endcase
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control and configuration registers
  // ----------------------------------------------------------------
  // Reserved bit six of control always reads zero
  always_ff @(posedge clk) begin
    if (reset) begin
      ctl_q    <= sraf_pkg::CTL_RESET;
      error_irq_en_q  <= sraf_pkg::STS_RESET[sraf_pkg::STS_ERROR_IRQ_EN];
      mode_fault_detect_en_q <= sraf_pkg::STS_RESET[sraf_pkg::STS_MODE_FAULT_EN];
      rate_q   <= sraf_pkg::STS_RESET[sraf_pkg::STS_RATE_HI:sraf_pkg::STS_RATE_LO];
    end else if (doWrite && wLane_q) begin
      if (awAddr_q == sraf_pkg::PORT_CONTROL_ADDR) begin
        ctl_q <= wByte_q & sraf_pkg::CTL_WMASK;
      end
      if (awAddr_q == sraf_pkg::PORT_STATUS_CONTROL_ADDR) begin
        error_irq_en_q  <= wByte_q[sraf_pkg::STS_ERROR_IRQ_EN];
        mode_fault_detect_en_q <= wByte_q[sraf_pkg::STS_MODE_FAULT_EN];
        rate_q   <= wByte_q[sraf_pkg::STS_RATE_HI:sraf_pkg::STS_RATE_LO];
      end
    end
  end

  // ----------------------------------------------------------------
  // Transfer engine
  // ----------------------------------------------------------------
  logic loadNow, edgeGo, lead, start;
  logic [7:0] rxByte;
  // Idle port moves a waiting byte at once; a running one waits
  assign loadNow = enable & txFull_q & (state_q == sraf_pkg::ST_IDLE);
  assign start   = ~ctrlRole & ~clock_phase & ssFall & (state_q == sraf_pkg::ST_IDLE);
  // Target follows synced clock only while selected
  assign edgeGo  = ctrlRole ?
                   (state_q == sraf_pkg::ST_RUN) & (halfCnt_q == 8'h00) :
                   enable & sckChg & ssLow &
                   ((state_q == sraf_pkg::ST_RUN) |
                    ((state_q == sraf_pkg::ST_IDLE) & clock_phase));
  assign lead    = ~edgeCnt_q[0];
  assign rxByte  = clock_phase ? {shift_q[6:0], rxBit_q} : shift_q;

  // Transmit buffer; held empty while disabled, a write wins over a hand-over
  always_ff @(posedge clk) begin
    if (reset) begin
      txBuf_q  <= 8'h00;
      txFull_q <= 1'b0;
    end else if (!enable) begin
      txFull_q <= 1'b0;
    end else if (dataWr) begin
      txBuf_q  <= wByte_q;
      txFull_q <= 1'b1;
    end else if (loadNow) begin
      txFull_q <= 1'b0;
    end
  end

  // Shift, phase and edge sequencing for both roles
  always_ff @(posedge clk) begin
    if (reset || !enable) begin
      state_q   <= sraf_pkg::ST_IDLE;
      shift_q   <= 8'h00;
      rxBit_q   <= 1'b0;
      edgeCnt_q <= 4'h0;
      halfCnt_q <= 8'h00;
      sckLvl_q  <= 1'b0;
    end else begin
      case (state_q)
        sraf_pkg::ST_IDLE: begin
          sckLvl_q  <= clock_polarity;
          edgeCnt_q <= 4'h0;
          halfCnt_q <= 8'(rateDivisor(rate_q) - 8'h01);
          if (loadNow) begin
            shift_q <= txBuf_q;
          end
          if ((ctrlRole && loadNow) || start) begin
            state_q <= sraf_pkg::ST_RUN;
          end
        end
        sraf_pkg::ST_RUN: begin
          if (ctrlRole) begin
            halfCnt_q <= (halfCnt_q == 8'h00) ?
                         8'(rateDivisor(rate_q) - 8'h01) : 8'(halfCnt_q - 8'h01);
          end
        end
        sraf_pkg::ST_DONE: begin
          state_q  <= sraf_pkg::ST_IDLE;
          sckLvl_q <= clock_polarity;
        end
        default: state_q <= sraf_pkg::ST_IDLE;
      endcase
      // Edge work; a phase-one target enters the run state on its first edge
      if (edgeGo) begin
        if (ctrlRole) begin
          sckLvl_q <= ~sckLvl_q;
        end
        if (lead == ~clock_phase) begin
          rxBit_q <= serIn;
        end else if (!(lead && edgeCnt_q == 4'h0)) begin
          shift_q <= {shift_q[6:0], rxBit_q};
        end
        edgeCnt_q <= 4'(edgeCnt_q + 4'h1);
        state_q   <= (edgeCnt_q == sraf_pkg::LAST_EDGE) ?
                     sraf_pkg::ST_DONE : sraf_pkg::ST_RUN;
      end
    end
  end

  // ----------------------------------------------------------------
  // Flags and their clearing sequences
  // ----------------------------------------------------------------
  logic modfSet;
  // Controller with detect off ignores select entirely
  assign modfSet = enable & mode_fault_detect_en_q &
                   (ctrlRole ? ssLow : ssRise & (state_q == sraf_pkg::ST_RUN));

  // Received byte lands unless the last one is still unread
  always_ff @(posedge clk) begin
    if (reset) begin
      rxData_q <= 8'h00;
      rxFull_q <= 1'b0;
      ovr_q    <= 1'b0;
      ovrArm_q <= 1'b0;
    end else begin
      if (statusRd) begin
        ovrArm_q <= ovr_q;
      end else if (dataRd) begin
        ovrArm_q <= 1'b0;
      end
      if (state_q == sraf_pkg::ST_DONE && rxFull_q && !dataRd) begin
        ovr_q <= 1'b1;
      end else if (dataRd && ovrArm_q) begin
        ovr_q <= 1'b0;
      end
      // A read in the landing cycle frees the slot, so the new byte wins
      if (state_q == sraf_pkg::ST_DONE && (!rxFull_q || dataRd)) begin
        rxData_q <= rxByte;
        rxFull_q <= 1'b1;
      end else if (dataRd) begin
        rxFull_q <= 1'b0;
      end
    end
  end

  // Fault flag survives detect-enable being cleared
  always_ff @(posedge clk) begin
    if (reset) begin
      mode_fault_flag_q    <= 1'b0;
      modfArm_q <= 1'b0;
    end else begin
      if (statusRd) begin
        modfArm_q <= mode_fault_flag_q;
      end else if (dataWr) begin
        modfArm_q <= 1'b0;
      end
      if (modfSet) begin
        mode_fault_flag_q <= 1'b1;
      end else if (dataWr && modfArm_q) begin
        mode_fault_flag_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt request and pin drivers
  // ----------------------------------------------------------------
  assign irqReq = (rxIe & rxFull_q) |
                  (txIe & ~txFull_q) |
                  (error_irq_en_q & (ovr_q | mode_fault_flag_q));

  // MISO only while selected as target; open drain when wired-OR
  logic [1:0] sckPad, mosiPad, misoPad;
  assign sckPad  = padDrive(sckLvl_q, wom, enable & ctrlRole);
  assign mosiPad = padDrive(shift_q[7], wom, enable & ctrlRole);
  assign misoPad = padDrive(shift_q[7], wom, enable & ~ctrlRole & ssLow);
  assign pinOut  = '{sck: sckPad[1], mosi: mosiPad[1], miso: misoPad[1]};
  assign pinOe   = '{sck: sckPad[0], mosi: mosiPad[0], miso: misoPad[0]};

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_rx_full_set:   assert property ((state_q == sraf_pkg::ST_DONE &&
                     (!rxFull_q || dataRd)) |=> rxFull_q && rxData_q == $past(rxByte))
                     else $error("rx byte not stored");
  a_overrun_keep:  assert property ((state_q == sraf_pkg::ST_DONE && rxFull_q &&
                     !dataRd) |=> ovr_q && $stable(rxData_q))
                     else $error("overrun mishandled");
  a_idle_load:     assert property ((dataWr && state_q == sraf_pkg::ST_IDLE && enable &&
                     !start && !edgeGo) |-> ##[1:2] !txFull_q) else $error("idle load late");
  a_ovr_clear:     assert property ($fell(ovr_q) |-> $past(dataRd && ovrArm_q))
                     else $error("overrun cleared without sequence");
  a_mode_fault_flag_clear:    assert property ($fell(mode_fault_flag_q) |-> $past(dataWr && modfArm_q))
                     else $error("fault cleared without sequence");
  a_miso_release:  assert property ((!ctrlRole && !ssLow) |-> !pinOe.miso)
                     else $error("miso driven while deselected");
  a_edge_freeze:   assert property ((enable && !ctrlRole && !ssLow &&
                     state_q == sraf_pkg::ST_RUN) |=> $stable(edgeCnt_q))
                     else $error("clock not ignored");
  a_rate_reload:   assert property ((enable && ctrlRole && halfCnt_q == 8'h00 &&
                     state_q == sraf_pkg::ST_RUN && edgeCnt_q != sraf_pkg::LAST_EDGE) |=>
                     halfCnt_q == 8'(rateDivisor($past(rate_q)) - 8'h01))
                     else $error("rate divisor wrong");
  a_wired_or:      assert property (wom |-> !pinOut.sck && !pinOut.mosi && !pinOut.miso)
                     else $error("open drain drives high");
  a_disable_idle:  assert property (!enable |=> state_q == sraf_pkg::ST_IDLE && !txFull_q)
                     else $error("partial reset missing");

  c_overrun:    cover property (state_q == sraf_pkg::ST_DONE && rxFull_q);
  c_mode_fault: cover property ($rose(mode_fault_flag_q));
  c_ctrl_byte:  cover property (ctrlRole && state_q == sraf_pkg::ST_DONE);
  c_tgt_byte:   cover property (!ctrlRole && state_q == sraf_pkg::ST_DONE);

endmodule : sraf_core

// ---- test/sraf_far_target.sv ----
`timescale 1ns/1ns
// ------------------------------------------
// Far-end target, polarity 0, phase 1
// ------------------------------------------
module sraf_far_target (
  input  wire logic       sck,    // Serial clock in
  input  wire logic       mosi,   // Controller data
  output logic            miso,   // Target data
  input  wire logic [7:0] txByte, // Reply byte
  output logic [7:0]      rxByte, // Last byte in
  output int              count   // Bytes done
);
  logic [7:0] sh;
  int         bits;
  logic       armed;
  initial begin
    {miso, sh, bits, count, rxByte, armed} = '0;
  end
  // Leading edge puts out next bit, MSB first
  always @(posedge sck) begin
    armed = 1'b1;
    miso = txByte[7 - bits];
  end
  // Trailing edge samples; armed blocks a false edge at start-up
  always @(negedge sck) begin
    if (armed) begin
      sh = {sh[6:0], mosi};
      bits = bits + 1;
      if (bits == 8) begin
        bits = 0;
        rxByte = sh;
        miso = ~miso; // Released line must not look held
        count = count + 1;
      end
    end
  end
endmodule : sraf_far_target

// ---- test/sraf_bench.sv ----
`timescale 1ns/1ns
// ------------------------------------------
// Register-level bench, port as controller
// ------------------------------------------
module sraf_bench;
  localparam logic [7:0] CTL = sraf_pkg::PORT_CONTROL_ADDR;
  localparam logic [7:0] STS = sraf_pkg::PORT_STATUS_CONTROL_ADDR;
  localparam logic [7:0] DAT = sraf_pkg::PORT_DATA_ADDR;
  logic clk, reset, awvalid, wvalid, bready, arvalid, rready, selectN;
  logic awready, wready, arready, bvalid, rvalid, irqReq, sckLine, mosiLine, misoLine;
  logic [7:0] awaddr, araddr, txByte, rxByte, d;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r, rb;
  sraf_pkg::sraf_pins_t pinIn, pinOut, pinOe;
  int fail_count, tests_run, cyc, done;
  // Undriven lines fall to their idle levels
  assign sckLine = (pinOe.sck === 1'b1) ? pinOut.sck : 1'b0;
  assign mosiLine = (pinOe.mosi === 1'b1) ? pinOut.mosi : 1'b1;
  assign pinIn = {sckLine, mosiLine, misoLine};
  sraf_core u_dut (.clk, .reset, .awvalid, .awready, .awaddr, .wvalid, .wready,
    .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
    .rvalid, .rready, .rdata, .rresp, .pinIn, .pinOut, .pinOe, .selectN, .irqReq);
  sraf_far_target u_far (.sck(sckLine), .mosi(mosiLine), .miso(misoLine),
    .txByte, .rxByte, .count(done));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Both channels offered together, each dropped once taken
  task wr(input logic [7:0] a, input logic [7:0] v);
    logic ta, tw, tb;
    {ta, tw, tb} = '0;
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ta && tw)) begin
      #1;
      ta = ta | awready;
      tw = tw | wready;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    while (!tb) begin
      #1;
      tb = bvalid;
      rb = bresp;
      @(posedge clk);
    end
  endtask : wr
  task rc(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
    logic t;
    t = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    while (!t) begin
      #1;
      t = arready;
      @(posedge clk);
    end
    arvalid <= 1'b0;
    t = 1'b0;
    while (!t) begin
      #1;
      t = rvalid;
      d = rdata[7:0];
      r = rresp;
      @(posedge clk);
    end
    chk($sformatf("reg %h", a), e, d & m);
  endtask : rc
  // Data written only with tx empty; waits for far end byte
  task xfer(input logic [7:0] v);
    int n;
    n = done;
    wr(DAT, v);
    wait (done != n);
    repeat (6) @(posedge clk);
  endtask : xfer
  task test_done();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done
  // Hang guard, well above the several hundred cycles needed
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      test_done();
    end
  end
  initial begin
    reset = 1'b1;
    {awvalid, wvalid, arvalid, cyc, fail_count, tests_run} = '0;
    {bready, rready, selectN, wstrb} = '1;
    {awaddr, araddr, wdata, txByte} = '0;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rc(CTL, 8'h28);
    rc(STS, 8'h08);
    rc(8'h00, 8'h00);
    chk("resp", 8'h03, {6'h0, r});
    chk("irq", 8'h00, {7'h0, irqReq});
    chk("pin oe", 8'h00, {5'h0, pinOe});
    wr(8'h00, 8'h00);
    chk("bresp", 8'h03, {6'h0, rb});
    $display("test reset done");
    wr(STS, 8'h01);
    chk("bresp", 8'h00, {6'h0, rb});
    wr(CTL, 8'h2a);
    txByte = 8'ha5;
    xfer(8'h3c);
    rc(STS, 8'h89);
    chk("far rx", 8'h3c, rxByte);
    rc(DAT, 8'ha5);
    rc(STS, 8'h09);
    $display("test transfer done");
    txByte = 8'h11;
    xfer(8'h22);
    txByte = 8'h33;
    xfer(8'h44);
    rc(DAT, 8'h11);
    rc(STS, 8'h29);
    rc(DAT, 8'h11);
    rc(STS, 8'h09);
    $display("test overrun done");
    wr(CTL, 8'haa);
    chk("irq", 8'h00, {7'h0, irqReq});
    xfer(8'h55);
    chk("irq", 8'h01, {7'h0, irqReq});
    rc(DAT, 8'h33);
    wr(CTL, 8'h2b);
    chk("irq", 8'h01, {7'h0, irqReq});
    wr(CTL, 8'h2a);
    chk("irq", 8'h00, {7'h0, irqReq});
    chk("sck oe", 8'h01, {7'h0, pinOe.sck});
    wr(CTL, 8'h2e);
    chk("sck oe", 8'h01, {7'h0, pinOe.sck});
    chk("pin out", 8'h00, {5'h0, pinOut});
    wr(CTL, 8'h2a);
    $display("test irq done");
    wr(STS, 8'h05);
    selectN <= 1'b0;
    repeat (8) @(posedge clk);
    selectN <= 1'b1;
    repeat (8) @(posedge clk);
    rc(STS, 8'h1d);
    wr(STS, 8'h41);
    rc(STS, 8'h59);
    chk("irq", 8'h01, {7'h0, irqReq});
    wr(DAT, 8'h00);
    rc(STS, 8'h00, 8'h10);
    chk("irq", 8'h00, {7'h0, irqReq});
    $display("test fault done");
    test_done();
  end
endmodule : sraf_bench
